// File: core/crs_pkg.sv
// Constants, types and reset state shared by the CPU reset and interrupt
// signal block. Assumes one 250 MHz clock and an 8-bit register port.
package crs_pkg;

    localparam int CLK_HZ = 250_000_000;
    localparam int INIT_CYCLES = 4;
    localparam int HRST_TIME_MS = 1;
    localparam int HRST_CYCLES = HRST_TIME_MS * (CLK_HZ / 1000);
    localparam int CNT_W = 20;

    localparam int ADDR_W = 12;
    localparam int DATA_W = 8;
    localparam int N_IRQ = 16;
    localparam int EV_W = 4;
    localparam int SYNC_W = N_IRQ + 2;

    localparam logic [ADDR_W-1:0] ADDR_AT_CTRL = 12'h04e;
    localparam logic [ADDR_W-1:0] ADDR_PORT92 = 12'h092;
    localparam logic [ADDR_W-1:0] ADDR_TRIG_LO = 12'h4d0;
    localparam logic [ADDR_W-1:0] ADDR_TRIG_HI = 12'h4d1;
    localparam logic [ADDR_W-1:0] ADDR_EVT_STAT = 12'h0f0;
    localparam logic [ADDR_W-1:0] ADDR_EVT_MASK = 12'h0f1;
    localparam logic [ADDR_W-1:0] ADDR_PEND_LO = 12'h0f2;
    localparam logic [ADDR_W-1:0] ADDR_PEND_HI = 12'h0f3;
    localparam logic [ADDR_W-1:0] ADDR_CHMASK_LO = 12'h0f4;
    localparam logic [ADDR_W-1:0] ADDR_CHMASK_HI = 12'h0f5;

    localparam int P92_HOT_RESET = 0;
    localparam int P92_STRAP = 2;
    localparam int AT_KBD_RESET = 1;
    localparam int AT_FPU_EN = 4;
    localparam int AT_IGNORE_NUMERIC_ERROR = 5;

    localparam int EV_INIT = 0;
    localparam int EV_HRST = 1;
    localparam int EV_SHUTDOWN = 2;
    localparam int EV_FPU = 3;

    localparam int CH_TIMER = 0;
    localparam int CH_CASCADE = 2;
    localparam int CH_RTC = 8;
    localparam int CH_COPROC = 13;
    localparam logic [N_IRQ-1:0] TRIG_FIXED_EDGE = 16'h2105;
    localparam logic [N_IRQ-1:0] CHMASK_RST = 16'hffff;
    // Inverted lines read high while the synchroniser is still clear
    localparam logic [N_IRQ-1:0] SRC_PREV_RST = 16'h2100;
    // Enabled edges before the synchronised strap is valid
    localparam int STRAP_SYNC = 2;

    typedef enum logic {HM_PC, HM_ALT} crs_host_mode_t;
    typedef enum logic {PLS_IDLE, PLS_ACTIVE} crs_pls_t;

    typedef struct packed {
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] wdata;
        logic wr;
        logic rd;
    } crs_reg_req_t;

    typedef struct packed {
        logic [SYNC_W-1:0] meta;
        logic [SYNC_W-1:0] stable;
    } crs_sync_t;

    typedef struct packed {
        crs_host_mode_t mode;
        logic strap_done;
        logic [1:0] strap_age;
        crs_pls_t pls;
        logic [CNT_W-1:0] cnt;
        logic pg_prev;
        logic [N_IRQ-1:0] src_prev;
        logic [N_IRQ-1:0] pending;
        logic [N_IRQ-1:0] chmask;
        logic [N_IRQ-1:0] trig;
        logic hot_reset;
        logic kbd_reset;
        logic fpu_en;
        logic ignore_numeric_error_req;
        logic fpu_prev;
        logic [EV_W-1:0] evt_stat;
        logic [EV_W-1:0] evt_mask;
        logic [DATA_W-1:0] rd_data;
        logic init_o;
        logic hrst_o;
        logic ignore_numeric_error_o;
        logic cpu_int_o;
        logic evt_irq_o;
    } crs_state_t;

    localparam crs_state_t ST_RST = '{
        mode: HM_PC,
        pls: PLS_IDLE,
        chmask: CHMASK_RST,
        src_prev: SRC_PREV_RST,
        default: '0
    };

endpackage : crs_pkg

// File: core/crs_sync.sv
// Two-flop synchroniser bank for the pin inputs of the reset block.
// Assumes the inputs are asynchronous to clk_in.
`timescale 1ns/1ns
module crs_sync (
    input wire logic clk_in,
    input wire logic reset_in,
    input wire logic ce_in,
    input wire logic [crs_pkg::SYNC_W-1:0] d_in,
    output logic [crs_pkg::SYNC_W-1:0] q_out
);

    crs_pkg::crs_sync_t st;
    crs_pkg::crs_sync_t next_st;

    always_comb begin
        next_st = st;
        next_st.meta = d_in;
        next_st.stable = st.meta;
    end

    always_ff @(posedge clk_in or posedge reset_in) begin
        if (reset_in) begin
            st <= '0;
        end else if (ce_in) begin
            st <= next_st;
        end
    end

    assign q_out = st.stable;

endmodule : crs_sync

// File: core/crs_cpu_ctrl.sv
// CPU-side reset, initialise and interrupt signals of a system I/O block.
// Assumes a 250 MHz clock, pins sampled through crs_sync, and an 8-bit
// register port with read data one cycle after the read strobe.
//
// Function
// R01: In the compatible mode a hot reset, a shutdown or a keyboard reset gives a four-clock init pulse.
// R02: A strap caught after reset picks the host mode, which decides what the shared outputs do.
// R03: In the alternate mode power good rising, hot reset, shutdown or keyboard reset give a 1 ms host reset.
// R04: System reset outputs are derived from the power good input of the supply; only host reset uses it, and only in the alternate mode.
// R05: The shared input is channel 13 by default and acts as the numeric error input only when enabled.
// R06: The CPU interrupt output is high while the controller holds a pending unmasked request.
// R07: Two cascaded controllers serve fifteen request channels.
// R08: Channel 0 comes from the timer counter 0 output, not from a pin.
// R09: Requests trigger on rising edges, the clock and coprocessor lines on falling edges.
// R10: Two trigger-mode registers switch single channels from edge to level triggering.
// R11: External request inputs have no internal pull-ups.
// R12: The block has a reset state forcing known values and an active state.
// R13: A new event during a running pulse restarts its full length.
//
// The placing of the registers and the strobed register port were chosen for this implementation.
`timescale 1ns/1ns
module crs_cpu_ctrl #(
    parameter int unsigned HRST_CYCLES = crs_pkg::HRST_CYCLES
) (
    input wire logic clk_in,
    input wire logic reset_in,
    input wire logic ce_in,
    input wire crs_pkg::crs_reg_req_t reg_req_in,
    output logic [crs_pkg::DATA_W-1:0] reg_rd_data_out,
    input wire logic power_good_in,
    input wire logic mode_strap_in,
    input wire logic [crs_pkg::N_IRQ-1:0] irq_pins_in,
    input wire logic timer_zero_output_in,
    input wire logic cpu_shutdown_in,
    output logic cpu_init_pulse_out,
    output logic host_reset_out,
    output logic ignore_numeric_error_out,
    output logic cpu_interrupt_out,
    output logic evt_irq_out,
    output logic alt_mode_out
);

    localparam logic [crs_pkg::CNT_W-1:0] INIT_LOAD =
        crs_pkg::CNT_W'(crs_pkg::INIT_CYCLES);
    localparam logic [crs_pkg::CNT_W-1:0] HRST_LOAD =
        crs_pkg::CNT_W'(HRST_CYCLES);

    crs_pkg::crs_state_t st;
    crs_pkg::crs_state_t next_st;
    logic [crs_pkg::SYNC_W-1:0] pins_s;
    logic [crs_pkg::N_IRQ-1:0] src;
    logic [crs_pkg::N_IRQ-1:0] rise;
    logic [crs_pkg::N_IRQ-1:0] trig_eff;
    logic pg_s;
    logic strap_s;
    logic pg_rise;
    logic fpu_fall;
    logic ev_pc;
    logic ev_alt;
    logic load_init;
    logic load_hrst;

    // Pins carry no pull-ups; floating lines are the board's concern [R11]
    crs_sync u_sync (
        .clk_in(clk_in),
        .reset_in(reset_in),
        .ce_in(ce_in),
        .d_in({mode_strap_in, power_good_in, irq_pins_in}),
        .q_out(pins_s)
    );

    assign pg_s = pins_s[crs_pkg::N_IRQ];
    assign strap_s = pins_s[crs_pkg::N_IRQ+1];

    function automatic logic wr_hit(input crs_pkg::crs_reg_req_t r,
                                    input logic [crs_pkg::ADDR_W-1:0] a);
        wr_hit = r.wr && (r.addr == a);
    endfunction : wr_hit

    function automatic logic [crs_pkg::DATA_W-1:0] reg_read(
        input crs_pkg::crs_state_t s,
        input logic [crs_pkg::ADDR_W-1:0] a);
        logic [crs_pkg::DATA_W-1:0] v;
        v = 8'h00;
        unique case (a)
            crs_pkg::ADDR_AT_CTRL: begin
                v[crs_pkg::AT_KBD_RESET] = s.kbd_reset;
                v[crs_pkg::AT_FPU_EN] = s.fpu_en;
                v[crs_pkg::AT_IGNORE_NUMERIC_ERROR] = s.ignore_numeric_error_req;
            end
            crs_pkg::ADDR_PORT92: begin
                v[crs_pkg::P92_HOT_RESET] = s.hot_reset;
                v[crs_pkg::P92_STRAP] = (s.mode == crs_pkg::HM_ALT);
            end
            crs_pkg::ADDR_TRIG_LO: v = s.trig[7:0];
            crs_pkg::ADDR_TRIG_HI: v = s.trig[15:8];
            crs_pkg::ADDR_EVT_STAT: v = {4'h0, s.evt_stat};
            crs_pkg::ADDR_EVT_MASK: v = {4'h0, s.evt_mask};
            crs_pkg::ADDR_PEND_LO: v = s.pending[7:0];
            crs_pkg::ADDR_PEND_HI: v = s.pending[15:8];
            crs_pkg::ADDR_CHMASK_LO: v = s.chmask[7:0];
            crs_pkg::ADDR_CHMASK_HI: v = s.chmask[15:8];
            default: v = 8'h00;
        endcase
        reg_read = v;
    endfunction : reg_read

    always_comb begin
        next_st = st;

        // Mode strap caught once the cleared synchroniser holds the pin
        if (!st.strap_done) begin // [R02] [R12]
            if (st.strap_age == 2'(crs_pkg::STRAP_SYNC)) begin
                next_st.mode = strap_s ? crs_pkg::HM_ALT : crs_pkg::HM_PC;
                next_st.strap_done = 1'b1;
            end else begin
                next_st.strap_age = st.strap_age + 2'h1;
            end
        end

        // Channel sources: timer on 0, cascade on 2, inverted on 8 and 13
        src = pins_s[crs_pkg::N_IRQ-1:0];
        src[crs_pkg::CH_TIMER] = timer_zero_output_in; // [R08]
        src[crs_pkg::CH_CASCADE] = 1'b0; // [R07]
        src[crs_pkg::CH_RTC] = ~pins_s[crs_pkg::CH_RTC]; // [R09]
        src[crs_pkg::CH_COPROC] = ~pins_s[crs_pkg::CH_COPROC]; // [R05] [R09]
        rise = src & ~st.src_prev;
        next_st.src_prev = src;
        trig_eff = st.trig & ~crs_pkg::TRIG_FIXED_EDGE; // [R09] [R10]

        // Edge channels latch and clear by write-one; a new edge wins
        next_st.pending = st.pending;
        if (wr_hit(reg_req_in, crs_pkg::ADDR_PEND_LO)) begin
            next_st.pending[7:0] = st.pending[7:0] & ~reg_req_in.wdata;
        end
        if (wr_hit(reg_req_in, crs_pkg::ADDR_PEND_HI)) begin
            next_st.pending[15:8] = st.pending[15:8] & ~reg_req_in.wdata;
        end
        next_st.pending = (trig_eff & src)
            | (~trig_eff & (next_st.pending | rise)); // [R09] [R10]
        next_st.pending[crs_pkg::CH_CASCADE] = 1'b0; // [R07]

        // Register writes
        if (wr_hit(reg_req_in, crs_pkg::ADDR_TRIG_LO)) begin
            next_st.trig[7:0] = reg_req_in.wdata; // [R10]
        end
        if (wr_hit(reg_req_in, crs_pkg::ADDR_TRIG_HI)) begin
            next_st.trig[15:8] = reg_req_in.wdata; // [R10]
        end
        if (wr_hit(reg_req_in, crs_pkg::ADDR_CHMASK_LO)) begin
            next_st.chmask[7:0] = reg_req_in.wdata;
        end
        if (wr_hit(reg_req_in, crs_pkg::ADDR_CHMASK_HI)) begin
            next_st.chmask[15:8] = reg_req_in.wdata;
        end
        if (wr_hit(reg_req_in, crs_pkg::ADDR_EVT_MASK)) begin
            next_st.evt_mask = reg_req_in.wdata[crs_pkg::EV_W-1:0];
        end
        if (wr_hit(reg_req_in, crs_pkg::ADDR_AT_CTRL)) begin
            next_st.kbd_reset = reg_req_in.wdata[crs_pkg::AT_KBD_RESET];
            next_st.fpu_en = reg_req_in.wdata[crs_pkg::AT_FPU_EN];
            next_st.ignore_numeric_error_req = reg_req_in.wdata[crs_pkg::AT_IGNORE_NUMERIC_ERROR];
        end
        if (wr_hit(reg_req_in, crs_pkg::ADDR_PORT92)) begin
            next_st.hot_reset = reg_req_in.wdata[crs_pkg::P92_HOT_RESET];
        end

        // Reset events: bits count only on a 0 to 1 change
        pg_rise = pg_s && !st.pg_prev; // [R04]
        next_st.pg_prev = pg_s;
        ev_pc = (next_st.hot_reset && !st.hot_reset)
            || (next_st.kbd_reset && !st.kbd_reset)
            || cpu_shutdown_in; // [R01]
        ev_alt = ev_pc || pg_rise || !pg_s; // [R03] [R04]
        load_init = (next_st.mode == crs_pkg::HM_PC) && ev_pc;
        load_hrst = (next_st.mode == crs_pkg::HM_ALT) && ev_alt;

        // Pulse timer; any new event reloads the full length
        unique case (st.pls)
            crs_pkg::PLS_IDLE: begin
                if (load_init || load_hrst) begin
                    next_st.pls = crs_pkg::PLS_ACTIVE;
                end
            end
            crs_pkg::PLS_ACTIVE: begin
                if (!(load_init || load_hrst) && st.cnt == 20'h00001) begin
                    next_st.pls = crs_pkg::PLS_IDLE;
                end
            end
        endcase
        if (load_init) begin
            next_st.cnt = INIT_LOAD; // [R01] [R13]
        end else if (load_hrst) begin
            next_st.cnt = HRST_LOAD; // [R03] [R13]
        end else if (st.cnt != '0) begin
            next_st.cnt = st.cnt - 20'h00001;
        end

        // Numeric error seen only while the shared input is enabled for it
        fpu_fall = !pins_s[crs_pkg::CH_COPROC] && st.fpu_prev;
        next_st.fpu_prev = pins_s[crs_pkg::CH_COPROC];

        // Sticky event status, write one to clear, set wins over clear
        if (wr_hit(reg_req_in, crs_pkg::ADDR_EVT_STAT)) begin
            next_st.evt_stat = st.evt_stat
                & ~reg_req_in.wdata[crs_pkg::EV_W-1:0];
        end
        next_st.evt_stat[crs_pkg::EV_INIT] =
            next_st.evt_stat[crs_pkg::EV_INIT] | load_init;
        next_st.evt_stat[crs_pkg::EV_HRST] =
            next_st.evt_stat[crs_pkg::EV_HRST] | (load_hrst && pg_s);
        next_st.evt_stat[crs_pkg::EV_SHUTDOWN] =
            next_st.evt_stat[crs_pkg::EV_SHUTDOWN] | cpu_shutdown_in;
        next_st.evt_stat[crs_pkg::EV_FPU] =
            next_st.evt_stat[crs_pkg::EV_FPU]
            | (st.fpu_en && fpu_fall); // [R05]

        // Read data stand only in the cycle after the strobe
        next_st.rd_data = reg_req_in.rd ? reg_read(st, reg_req_in.addr)
                                        : 8'h00;

        // Registered outputs; mode decides which shared function is live
        next_st.init_o = (next_st.mode == crs_pkg::HM_PC)
            && (next_st.cnt != '0); // [R01] [R02]
        next_st.hrst_o = (next_st.mode == crs_pkg::HM_ALT)
            && (next_st.cnt != '0); // [R02] [R03]
        next_st.ignore_numeric_error_o = (next_st.mode == crs_pkg::HM_PC)
            && next_st.ignore_numeric_error_req; // [R02]
        next_st.cpu_int_o = |(next_st.pending & ~next_st.chmask); // [R06]
        next_st.evt_irq_o = |(next_st.evt_stat & next_st.evt_mask);
    end

    always_ff @(posedge clk_in or posedge reset_in) begin
        if (reset_in) begin
            st <= crs_pkg::ST_RST; // [R12]
        end else if (ce_in) begin
            st <= next_st;
        end
    end

    assign reg_rd_data_out = st.rd_data;
    assign cpu_init_pulse_out = st.init_o;
    assign host_reset_out = st.hrst_o;
    assign ignore_numeric_error_out = st.ignore_numeric_error_o;
    assign cpu_interrupt_out = st.cpu_int_o;
    assign evt_irq_out = st.evt_irq_o;
    assign alt_mode_out = (st.mode == crs_pkg::HM_ALT);

    default clocking cb @(posedge clk_in);
    endclocking
    default disable iff (reset_in);

    sequence s_pc_event;
        ce_in && load_init;
    endsequence

    sequence s_alt_event;
        ce_in && load_hrst;
    endsequence

    sequence s_edge5;
        ce_in && rise[5] && !trig_eff[5] && !st.chmask[5];
    endsequence

    chk_init_width: assert property ( // [R01]
        s_pc_event |=> cpu_init_pulse_out [*4])
        else $error("init pulse shorter than four clocks");

    chk_init_alt_quiet: assert property ( // [R02]
        (st.mode == crs_pkg::HM_ALT) && $stable(st.mode)
        |-> !cpu_init_pulse_out && !ignore_numeric_error_out)
        else $error("compatible-mode output active in alternate mode");

    chk_hrst_load: assert property ( // [R03]
        s_alt_event |=> host_reset_out && st.cnt == HRST_LOAD)
        else $error("host reset not loaded to full length");

    chk_pg_low_hold: assert property ( // [R04]
        ce_in && !pg_s && next_st.mode == crs_pkg::HM_ALT
        |=> host_reset_out [*2])
        else $error("host reset released while power not good");

    chk_fpu_flag: assert property ( // [R05]
        ce_in && st.fpu_en && fpu_fall |=> st.evt_stat[crs_pkg::EV_FPU])
        else $error("numeric error not flagged");

    chk_edge_to_int: assert property ( // [R06]
        s_edge5 ##1 ce_in |=> cpu_interrupt_out)
        else $error("unmasked edge request did not reach cpu");

    chk_cascade_idle: assert property ( // [R07]
        !st.pending[crs_pkg::CH_CASCADE])
        else $error("cascade channel shows a request");

    chk_timer_ch0: assert property ( // [R08]
        ce_in && timer_zero_output_in && !st.src_prev[crs_pkg::CH_TIMER]
        |=> st.pending[crs_pkg::CH_TIMER])
        else $error("timer edge did not raise channel 0");

    chk_rtc_falling: assert property ( // [R09]
        ce_in && $fell(pins_s[crs_pkg::CH_RTC])
        && !st.src_prev[crs_pkg::CH_RTC] |=> st.pending[crs_pkg::CH_RTC])
        else $error("falling edge on clock line not latched");

    chk_level_follow: assert property ( // [R10]
        ce_in && trig_eff[5] |=> st.pending[5] == $past(src[5]))
        else $error("level channel does not follow its source");

    chk_pulse_restart: assert property ( // [R13]
        s_pc_event and (st.cnt != '0) |=> st.cnt == INIT_LOAD)
        else $error("running pulse not restarted by new event");

endmodule : crs_cpu_ctrl

// File: bench/crs_host_model.sv
// Stand-in for the host processor: times the reset and initialise pulses
// it receives and issues shutdown cycles on request.
// Assumes the block's outputs are registered on the rising edge of clk_in.
`timescale 1ns/1ns
module crs_host_model (
    input wire logic clk_in,
    input wire logic reset_in,
    input wire logic init_in,
    input wire logic hrst_in,
    input wire logic shutdown_req_in,
    output logic shutdown_out,
    output logic [15:0] init_len_out,
    output logic [15:0] hrst_len_out
);
    logic [15:0] init_cnt;
    logic [15:0] hrst_cnt;

    // A processor held in reset runs no bus cycles
    assign shutdown_out = shutdown_req_in & ~hrst_in;

    always_ff @(posedge clk_in or posedge reset_in) begin
        if (reset_in) begin
            init_cnt <= '0;
            hrst_cnt <= '0;
            init_len_out <= '0;
            hrst_len_out <= '0;
        end else begin
            init_cnt <= init_in ? init_cnt + 16'h0001 : 16'h0000;
            hrst_cnt <= hrst_in ? hrst_cnt + 16'h0001 : 16'h0000;
            if (!init_in && init_cnt != 16'h0000) begin
                init_len_out <= init_cnt;
            end
            if (!hrst_in && hrst_cnt != 16'h0000) begin
                hrst_len_out <= hrst_cnt;
            end
        end
    end
endmodule : crs_host_model

// File: bench/cpu_reset_interrupt_signals_tb_top.sv
// Self-checking bench for the CPU reset and interrupt signal block.
// Assumes crs_pkg, crs_cpu_ctrl and crs_host_model are compiled first.
`timescale 1ns/1ns
module cpu_reset_interrupt_signals_tb_top;
    localparam int HRST = 20;
    logic clk_in = 1'b0;
    logic reset_in = 1'b1;
    crs_pkg::crs_reg_req_t req = '0;
    logic [7:0] rd_data;
    logic power_good = 1'b1;
    logic strap = 1'b0;
    logic [15:0] pins = 16'h2100;
    logic timer0 = 1'b0;
    logic sd_req = 1'b0;
    logic shutdown, init, hrst, ignore_numeric_error, cpu_int, evt_irq, alt_mode;
    logic [15:0] init_len, hrst_len, p, lvm;
    int errors = 0;
    int checks_done = 0;
    int g, lv, base;
    int lvls[12] = '{1, 3, 4, 5, 6, 7, 9, 10, 11, 12, 14, 15};

    crs_cpu_ctrl #(.HRST_CYCLES(HRST)) crs_cpu_ctrl_inst (
        .clk_in(clk_in), .reset_in(reset_in), .ce_in(1'b1),
        .reg_req_in(req), .reg_rd_data_out(rd_data),
        .power_good_in(power_good), .mode_strap_in(strap),
        .irq_pins_in(pins), .timer_zero_output_in(timer0),
        .cpu_shutdown_in(shutdown), .cpu_init_pulse_out(init),
        .host_reset_out(hrst), .ignore_numeric_error_out(ignore_numeric_error),
        .cpu_interrupt_out(cpu_int), .evt_irq_out(evt_irq),
        .alt_mode_out(alt_mode));
    crs_host_model crs_host_model_inst (
        .clk_in(clk_in), .reset_in(reset_in), .init_in(init),
        .hrst_in(hrst), .shutdown_req_in(sd_req), .shutdown_out(shutdown),
        .init_len_out(init_len), .hrst_len_out(hrst_len));

    initial begin
        forever #2 clk_in = ~clk_in;
    end

    function automatic logic exp_hit(input int ch);
        return !(ch == 0 || ch == 2);
    endfunction : exp_hit

    function automatic logic idle_lvl(input int ch);
        return ch == 8 || ch == 13;
    endfunction : idle_lvl

    task automatic check(input string what, input logic [15:0] e,
                         input logic [15:0] s);
        checks_done++;
        if (s !== e) begin
            errors++;
            $display("Error %s expected %h seen %h", what, e, s);
        end
    endtask : check

    task automatic chk1(input string what, input logic e, input logic s);
        check(what, {15'h0000, e}, {15'h0000, s});
    endtask : chk1

    task automatic cyc(input int n);
        repeat (n) @(posedge clk_in);
        #1;
    endtask : cyc

    task automatic reg_wr(input logic [11:0] a, input logic [7:0] d);
        @(posedge clk_in);
        req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
        @(posedge clk_in);
        req.wr <= 1'b0;
    endtask : reg_wr

    task automatic reg_rd(input logic [11:0] a, output logic [7:0] d);
        @(posedge clk_in);
        req <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
        @(posedge clk_in);
        req.rd <= 1'b0;
        #1;
        d = rd_data;
    endtask : reg_rd

    task automatic rd16(input logic [11:0] a, output logic [15:0] d);
        reg_rd(a, d[7:0]);
        reg_rd(a + 12'h001, d[15:8]);
    endtask : rd16

    task automatic wr16(input logic [11:0] a, input logic [15:0] d);
        reg_wr(a, d[7:0]);
        reg_wr(a + 12'h001, d[15:8]);
    endtask : wr16

    task automatic do_reset();
        @(posedge clk_in) reset_in <= 1'b1;
        repeat (2) @(posedge clk_in);
        reset_in <= 1'b0;
        cyc(4);
    endtask : do_reset

    // Ends at the edge that takes the event
    task automatic fire(input int e);
        if (e == 0) begin
            reg_wr(crs_pkg::ADDR_PORT92, 8'h01);
        end else if (e == 1) begin
            reg_wr(crs_pkg::ADDR_AT_CTRL, 8'h02);
        end else begin
            @(posedge clk_in) sd_req <= 1'b1;
            @(posedge clk_in) sd_req <= 1'b0;
        end
    endtask : fire

    task automatic unfire(input int e);
        if (e == 0) reg_wr(crs_pkg::ADDR_PORT92, 8'h00);
        if (e == 1) reg_wr(crs_pkg::ADDR_AT_CTRL, 8'h00);
    endtask : unfire

    task automatic wait_fall(input logic host);
        for (int i = 0; i < 60; i++) begin
            cyc(1);
            if ((host ? hrst : init) === 1'b0) break;
        end
        cyc(1);
    endtask : wait_fall

    task automatic print_verdict();
        $display("comparisons %0d mismatches %0d", checks_done, errors);
        if (errors == 0 && checks_done > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask : print_verdict

    initial begin
        repeat (20000) @(posedge clk_in);
        errors++;
        print_verdict();
    end

    initial begin
        void'($urandom(44));
        do_reset();
        check("outputs", 16'h0000, {10'h000, init, hrst, ignore_numeric_error, cpu_int,
              evt_irq, alt_mode});
        rd16(crs_pkg::ADDR_CHMASK_LO, p);
        check("channel mask", 16'hffff, p);
        rd16(crs_pkg::ADDR_TRIG_LO, p);
        check("trigger mode", 16'h0000, p);
        rd16(12'h0f8, p);
        check("unmapped", 16'h0000, p);
        $display("test reset_state done");
        wr16(crs_pkg::ADDR_CHMASK_LO, 16'h0000);
        base = $urandom_range(16);
        for (int k = 0; k < 17; k++) begin
            g = (k + base) % 17;
            @(posedge clk_in);
            if (g == 16) timer0 <= 1'b1;
            else pins[g] <= ~idle_lvl(g);
            cyc(6);
            chk1("cpu interrupt", exp_hit(g), cpu_int);
            rd16(crs_pkg::ADDR_PEND_LO, p);
            check("pending", exp_hit(g) ? 16'h0001 << (g % 16) : 16'h0000,
                  p);
            @(posedge clk_in);
            if (g == 16) timer0 <= 1'b0;
            else pins[g] <= idle_lvl(g);
            cyc(6);
            wr16(crs_pkg::ADDR_PEND_LO, 16'hffff);
            cyc(3);
            chk1("interrupt cleared", 1'b0, cpu_int);
        end
        rd16(crs_pkg::ADDR_EVT_STAT, p);
        check("no numeric error event", 16'h0000, p);
        $display("test channels done");
        lv = lvls[$urandom_range(11)];
        lvm = 16'h0001 << lv;
        wr16(crs_pkg::ADDR_TRIG_LO, lvm);
        rd16(crs_pkg::ADDR_TRIG_LO, p);
        check("trigger mode", lvm, p);
        @(posedge clk_in) pins[lv] <= 1'b1;
        cyc(6);
        wr16(crs_pkg::ADDR_PEND_LO, 16'hffff);
        rd16(crs_pkg::ADDR_PEND_LO, p);
        check("level held", lvm, p);
        @(posedge clk_in) pins[lv] <= 1'b0;
        cyc(6);
        rd16(crs_pkg::ADDR_PEND_LO, p);
        check("level dropped", 16'h0000, p);
        wr16(crs_pkg::ADDR_TRIG_LO, 16'hffff);
        @(posedge clk_in) pins[8] <= 1'b0;
        cyc(6);
        wr16(crs_pkg::ADDR_PEND_LO, 16'hffff);
        cyc(2);
        rd16(crs_pkg::ADDR_PEND_LO, p);
        check("fixed edge channel", 16'h0000, p);
        @(posedge clk_in) pins[8] <= 1'b1;
        wr16(crs_pkg::ADDR_TRIG_LO, 16'h0000);
        $display("test trigger_mode done");
        reg_wr(crs_pkg::ADDR_EVT_MASK, 8'h08);
        reg_wr(crs_pkg::ADDR_AT_CTRL, 8'h30);
        cyc(2);
        chk1("ignore numeric error", 1'b1, ignore_numeric_error);
        @(posedge clk_in) pins[13] <= 1'b0;
        cyc(6);
        chk1("event irq", 1'b1, evt_irq);
        reg_wr(crs_pkg::ADDR_EVT_STAT, 8'h08);
        cyc(2);
        chk1("event irq cleared", 1'b0, evt_irq);
        @(posedge clk_in) pins[13] <= 1'b1;
        reg_wr(crs_pkg::ADDR_AT_CTRL, 8'h00);
        wr16(crs_pkg::ADDR_PEND_LO, 16'hffff);
        $display("test numeric_error done");
        for (int e = 0; e < 3; e++) begin
            fire(e);
            wait_fall(1'b0);
            check("init length", 16'd4, init_len);
            unfire(e);
        end
        g = $urandom_range(2);
        fire(0);
        repeat (g) @(posedge clk_in);
        fire(2);
        wait_fall(1'b0);
        check("init restart", 16'(g + 6), init_len);
        unfire(0);
        check("no host reset", 16'h0000, hrst_len);
        reg_wr(crs_pkg::ADDR_EVT_MASK, 8'h01);
        cyc(2);
        chk1("event irq", 1'b1, evt_irq);
        reg_wr(crs_pkg::ADDR_EVT_STAT, 8'h05);
        cyc(2);
        chk1("event irq cleared", 1'b0, evt_irq);
        $display("test init_pulse done");
        @(posedge clk_in);
        strap <= 1'b1;
        power_good <= 1'b0;
        do_reset();
        chk1("alternate mode", 1'b1, alt_mode);
        chk1("host reset held", 1'b1, hrst);
        @(posedge clk_in) power_good <= 1'b1;
        wait_fall(1'b1);
        for (int e = 0; e < 3; e++) begin
            fire(e);
            wait_fall(1'b1);
            check("host reset length", 16'(HRST), hrst_len);
            unfire(e);
        end
        reg_wr(crs_pkg::ADDR_AT_CTRL, 8'h20);
        cyc(2);
        chk1("ignore numeric error", 1'b0, ignore_numeric_error);
        check("no init pulse", 16'h0000, init_len);
        $display("test alternate_mode done");
        print_verdict();
    end
endmodule : cpu_reset_interrupt_signals_tb_top
